// ===== ussi_status_irq.sv
// status flags, interrupt mask and wishbone slave of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "ussi_defines.svh"
module ussi_status_irq
    import ussi_pkg::*;
#(
    parameter bit FULL_MODEM = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic rxEnabled,
    input wire logic txEnabled,
    input wire logic rxCharDone,
    input wire logic rxHoldRead,
    input wire logic txHoldFull,
    input wire logic txShiftBusy,
    input wire logic startBreakPending,
    input wire logic breakEvent,
    input wire logic overrunEvent,
    input wire logic framingEvent,
    input wire logic parityEvent,
    input wire logic timeoutEvent,
    input wire logic [15:0] timeoutValue,
    input wire logic iterationEvent,
    input wire logic nackEvent,
    input wire logic receive_dma_done_flag,
    input wire logic transmit_dma_done_flag,
    input wire logic transmit_dma_buffer_empty_flag,
    input wire logic receive_dma_buffer_full_flag,
    input wire logic reset_status_command,
    input wire logic start_timeout_command,
    input wire logic reset_iterations_command,
    input wire logic reset_negative_acknowledge_command,
    input wire logic [3:0] modemPins
);
    // bit order of modem pins: 0 ring, 1 data-set-ready, 2 carrier, 3 clear-to-send
    ussi_state_t st_ff, nxt_st;
    logic [31:0] srcMask;
    logic [31:0] csrView;
    logic busReq, wrAcc, rdAcc, rdCsr;
    logic [3:0] modemEdge;

    // elaboration check of the variant switch
    if (FULL_MODEM != 1'b0 && FULL_MODEM != 1'b1) begin : g_bad_variant
        $error("bad FULL_MODEM");
    end

    // reduced variant drops three change sources
    assign srcMask = FULL_MODEM ? `USSI_SRC_MASK : `USSI_SRC_MASK_LITE;
    assign busReq = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wrAcc = busReq && wb_we_i && (wb_sel_i == 4'hf);
    assign rdAcc = busReq && !wb_we_i;
    assign rdCsr = rdAcc && (wb_adr_i == `USSI_OFF_CSR);

    // change when second and third stages agree and differ from held level
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_modem
            assign modemEdge[g] = (st_ff.modemSync[4 + g] == st_ff.modemSync[8 + g])
                && (st_ff.modemSync[8 + g] != st_ff.modemLvl[g]);
        end
    endgenerate

    always_comb begin
        csrView = 32'h0;
        csrView[13:0] = st_ff.flags;
        csrView[19:16] = st_ff.modemChg;
        csrView[23:20] = st_ff.modemLvl;
        csrView[`USSI_BIT_RX_READY] = st_ff.rxPend && rxEnabled;
        csrView[`USSI_BIT_TX_READY] = txEnabled && !txHoldFull && !startBreakPending;
        csrView[`USSI_BIT_TXIDLE] = txEnabled && !txHoldFull && !txShiftBusy;
        csrView[`USSI_BIT_RX_DMA_DONE] = receive_dma_done_flag;
        csrView[`USSI_BIT_TX_DMA_DONE] = transmit_dma_done_flag;
        csrView[`USSI_BIT_TX_DMA_EMPTY] = transmit_dma_buffer_empty_flag;
        csrView[`USSI_BIT_RX_DMA_FULL] = receive_dma_buffer_full_flag;
        csrView = csrView & (srcMask | 32'h00f00000);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.modemSync = {st_ff.modemSync[7:0], modemPins};
        nxt_st.modemLvl = st_ff.modemLvl ^ modemEdge;
        if (rxHoldRead) begin
            nxt_st.rxPend = 1'b0;
        end
        if (rxCharDone) begin
            nxt_st.rxPend = 1'b1;
        end
        if (reset_status_command) begin
            nxt_st.flags[`USSI_BIT_BRK] = 1'b0;
            nxt_st.flags[`USSI_BIT_OVERRUN] = 1'b0;
            nxt_st.flags[`USSI_BIT_FRAME] = 1'b0;
            nxt_st.flags[`USSI_BIT_PARITY] = 1'b0;
        end
        if (start_timeout_command) begin
            nxt_st.flags[`USSI_BIT_TOUT] = 1'b0;
        end
        if (reset_iterations_command) begin
            nxt_st.flags[`USSI_BIT_ITER] = 1'b0;
        end
        if (reset_negative_acknowledge_command) begin
            nxt_st.flags[`USSI_BIT_NEGATIVE_ACKNOWLEDGE_FLAG] = 1'b0;
        end
        if (breakEvent) begin
            nxt_st.flags[`USSI_BIT_BRK] = 1'b1;
        end
        if (overrunEvent) begin
            nxt_st.flags[`USSI_BIT_OVERRUN] = 1'b1;
        end
        if (framingEvent) begin
            nxt_st.flags[`USSI_BIT_FRAME] = 1'b1;
        end
        if (parityEvent) begin
            nxt_st.flags[`USSI_BIT_PARITY] = 1'b1;
        end
        if (timeoutEvent && timeoutValue != 16'h0) begin
            nxt_st.flags[`USSI_BIT_TOUT] = 1'b1;
        end
        if (iterationEvent) begin
            nxt_st.flags[`USSI_BIT_ITER] = 1'b1;
        end
        if (nackEvent) begin
            nxt_st.flags[`USSI_BIT_NEGATIVE_ACKNOWLEDGE_FLAG] = 1'b1;
        end
        if (rdCsr) begin
            nxt_st.modemChg = 4'h0;
        end
        nxt_st.modemChg = (nxt_st.modemChg | modemEdge) & srcMask[19:16];
        if (wrAcc && wb_adr_i == `USSI_OFF_IER) begin
            nxt_st.mask = (st_ff.mask | wb_dat_i) & srcMask;
        end
        if (wrAcc && wb_adr_i == `USSI_OFF_IDR) begin
            nxt_st.mask = st_ff.mask & ~wb_dat_i;
        end
        nxt_st.ack = busReq;
        nxt_st.rdat = 32'h0;
        if (rdAcc) begin
            case (wb_adr_i)
                `USSI_OFF_IMR: nxt_st.rdat = st_ff.mask;
                `USSI_OFF_CSR: nxt_st.rdat = csrView;
                default: nxt_st.rdat = 32'h0;
            endcase
        end
        nxt_st.irq = |(csrView[19:0] & st_ff.mask[19:0]);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.rdat;
    assign wb_ack_o = st_ff.ack;
    assign irq = st_ff.irq;
endmodule
`default_nettype wire

// ===== ussi_defines.svh
// register offsets, bit positions and reset values of the status and mask block
// Function
// - enable register write-only, sets mask bits
// - disable register write-only, clears mask bits
// - mask register read-only shows enabled sources
// - receiver ready while unread character, receiver on
// - receiver ready returns on re-enable if pending
// - transmitter ready low when holding full, break, off
// - transmitter ready rises once transmitter enabled
// - break flag sticky until reset-status
// - overrun flag sticky until reset-status
// - framing flag sticky until reset-status
// - parity flag sticky until reset-status
// - time-out flag set, cleared by start-timeout
// - time-out flag not set while time-out value zero
// - transmitter idle when holding and shifter empty
// - iteration flag sticky until reset-iterations
// - dma done flags mirror channel signals
// - dma buffer flags mirror channel signals
// - negative acknowledge sticky until its reset
// - modem input change flags set on change
// - status read clears modem change flags
// - reduced variant keeps only clear-to-send change
// - reset-status clears parity framing overrun break
// - reset-negative_acknowledge_flag command clears negative acknowledge flag
// - status shows present modem pin levels
`ifndef USSI_DEFINES_SVH
`define USSI_DEFINES_SVH
`define USSI_OFF_IER 4'h0
`define USSI_OFF_IDR 4'h4
`define USSI_OFF_IMR 4'h8
`define USSI_OFF_CSR 4'hc
`define USSI_OFF_CMD 4'h0
`define USSI_BIT_RX_READY 0
`define USSI_BIT_TX_READY 1
`define USSI_BIT_BRK 2
`define USSI_BIT_RX_DMA_DONE 3
`define USSI_BIT_TX_DMA_DONE 4
`define USSI_BIT_OVERRUN 5
`define USSI_BIT_FRAME 6
`define USSI_BIT_PARITY 7
`define USSI_BIT_TOUT 8
`define USSI_BIT_TXIDLE 9
`define USSI_BIT_ITER 10
`define USSI_BIT_TX_DMA_EMPTY 11
`define USSI_BIT_RX_DMA_FULL 12
`define USSI_BIT_NEGATIVE_ACKNOWLEDGE_FLAG 13
`define USSI_BIT_RING_CHG 16
`define USSI_BIT_CTS_CHG 19
`define USSI_BIT_RI 20
`define USSI_SRC_MASK 32'h000f3fff
`define USSI_SRC_MASK_LITE 32'h00083fff
`define USSI_MASK_RESET 32'h00000000
`endif

// ===== ussi_pkg.sv
// types for the status and mask block
package ussi_pkg;
    typedef struct packed {
        logic [31:0] mask;
        logic [13:0] flags;
        logic [3:0] modemChg;
        logic [3:0] modemLvl;
        logic [11:0] modemSync;
        logic rxPend;
        logic ack;
        logic [31:0] rdat;
        logic irq;
    } ussi_state_t;
endpackage

// ===== ussi_status_irq_checker.sv
// port assertions of the status and mask block
`timescale 1ns/1ps
`default_nettype none
module ussi_status_irq_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq,
    input wire logic rxEnabled,
    input wire logic txEnabled,
    input wire logic txHoldFull,
    input wire logic startBreakPending
);
    logic take;
    logic rdSt;
    logic transmitter_ready_flag;
    logic offAll;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rdSt = take && !wb_we_i && wb_adr_i == 4'hc;
    assign transmitter_ready_flag = txEnabled && !txHoldFull && !startBreakPending;
    assign offAll = take && wb_we_i && wb_adr_i == 4'h4 && wb_sel_i == 4'hf && &wb_dat_i;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    ack_timing_a: assert property (take |=> wb_ack_o)
        else $error("no ack");
    data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    write_quiet_a: assert property (take && wb_we_i |=> wb_dat_o == 32'h0)
        else $error("data on write");
    top_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h0)
        else $error("high bits set");
    rx_off_a: assert property (rdSt && !rxEnabled |=> !wb_dat_o[0])
        else $error("rx ready while off");
    tx_ready_a: assert property (rdSt |=> wb_dat_o[1] == $past(transmitter_ready_flag))
        else $error("tx ready wrong");
    mask_off_a: assert property (offAll |=> ##1 !irq)
        else $error("irq after disable");
endmodule
bind ussi_status_irq ussi_status_irq_checker ussi_status_irq_checker_i (.sys_clk, .rst_b,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .irq, .rxEnabled, .txEnabled, .txHoldFull, .startBreakPending);
`default_nettype wire

// ===== ussi_far_model.sv
// far-side model: line, receiver and command events as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module ussi_far_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [12:0] kick,
    output logic [12:0] ev
);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev <= '0;
        end else begin
            ev <= kick & ~ev;
        end
    end
endmodule
`default_nettype wire

// ===== test_ussi_status_irq.sv
// self-checking bench of the status and mask block
`timescale 1ns/1ps
`default_nettype none
module test_ussi_status_irq;
    logic sysClk = 1'b0;
    logic rstB = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ack;
    logic irq;
    logic [3:0] adr = 4'h0;
    logic [3:0] pins = 4'h0;
    logic [3:0] sel = 4'hf;
    logic [8:0] lv = '0;
    logic [12:0] kick = '0;
    logic [12:0] ev;
    logic [15:0] tov = 16'h10;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic [31:0] mk = '0;
    logic [31:0] rng = 32'h3f07;
    int sb[3] = '{8, 10, 13};
    int err_total = 0;
    int tests_run = 0;
    int cycN = 0;
    always #10 sysClk = ~sysClk;
    ussi_far_model ussi_far_model_i (.sys_clk(sysClk), .rst_b(rstB), .kick(kick), .ev(ev));
    ussi_status_irq ussi_status_irq_i (.sys_clk(sysClk), .rst_b(rstB), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .rxEnabled(lv[0]), .txEnabled(lv[1]),
        .rxCharDone(ev[11]), .rxHoldRead(ev[12]), .txHoldFull(lv[2]), .txShiftBusy(lv[3]),
        .startBreakPending(lv[4]), .breakEvent(ev[0]), .overrunEvent(ev[1]),
        .framingEvent(ev[2]), .parityEvent(ev[3]), .timeoutEvent(ev[4]), .timeoutValue(tov),
        .iterationEvent(ev[5]), .nackEvent(ev[6]), .receive_dma_done_flag(lv[5]),
        .transmit_dma_done_flag(lv[6]), .transmit_dma_buffer_empty_flag(lv[7]),
        .receive_dma_buffer_full_flag(lv[8]), .reset_status_command(ev[7]),
        .start_timeout_command(ev[8]), .reset_iterations_command(ev[9]),
        .reset_negative_acknowledge_command(ev[10]), .modemPins(pins));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] ex(logic [8:0] l);
        return {19'h0, l[8], l[7], 1'b0, l[1] & !l[2] & !l[3], 4'h0, l[6], l[5], 1'b0,
            l[1] & !l[2] & !l[4], 1'b0};
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sysClk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge sysClk);
        while (ack !== 1'b1) @(posedge sysClk);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, 4'hc, '0);
        chk("status", rd & m, e);
    endtask
    task automatic pulse(input logic [12:0] v);
        @(posedge sysClk);
        kick <= v;
        @(posedge sysClk);
        kick <= '0;
    endtask
    initial begin
        repeat (3) @(posedge sysClk);
        rstB <= 1'b1;
        wb(1'b0, 4'h8, '0);
        chk("mask", rd, '0);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            wb(1'b1, {1'b0, i[0], 2'b0}, rng);
            mk = i[0] ? mk & ~rng : mk | (rng & 32'h000f3fff);
            wb(1'b0, 4'h8, '0);
            chk("mask", rd, mk);
        end
        sel <= 4'h3;
        wb(1'b1, 4'h0, '1);
        sel <= 4'hf;
        wb(1'b0, 4'h8, '0);
        chk("mask", rd, mk);
        pulse(13'h000f);
        st(32'he4, 32'he4);
        st(32'he4, 32'he4);
        pulse(13'h0080);
        st(32'he4, '0);
        for (int i = 0; i < 3; i++) begin
            pulse(13'h10 << i);
            st(32'h1 << sb[i], 32'h1 << sb[i]);
            pulse(13'h100 << i);
            st(32'h1 << sb[i], '0);
        end
        tov <= '0;
        pulse(13'h10);
        st(32'h100, '0);
        pulse(13'h0800);
        st(32'h1, '0);
        lv <= 9'h001;
        st(32'h1, 32'h1);
        pulse(13'h1000);
        st(32'h1, '0);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            lv <= rng[8:0];
            st(32'h1a1a, ex(rng[8:0]));
        end
        pins <= 4'ha;
        repeat (6) @(posedge sysClk);
        st(32'hff0000, 32'haa0000);
        st(32'hff0000, 32'ha00000);
        lv <= 9'h080;
        wb(1'b1, 4'h0, 32'h800);
        wb(1'b0, 4'h8, '0);
        chk("irq", {31'h0, irq}, 32'h1);
        wb(1'b1, 4'h4, '1);
        wb(1'b0, 4'h8, '0);
        chk("irq", {31'h0, irq}, '0);
        close_out();
    end
    always @(posedge sysClk) begin
        cycN <= cycN + 1;
        if (cycN == 4000) begin
            err_total++;
            close_out();
        end
    end
endmodule
`default_nettype wire
